// ==== rtl/ocf_pkg.sv ====
// Purpose: Shared constants and types for the output channel fanout
// Assumes: 125 MHz aclk, AXI4-Lite register access
// Notes: Offsets are byte addresses of aligned 32-bit words
package ocf_pkg;
  localparam int unsigned OCF_UNITS = 8;
  localparam int unsigned OCF_CHAR_W = 8;
  localparam int unsigned OCF_CLK_MHZ = 125;
  // Alarm timeout and start-up hold-off, in their own units
  localparam int unsigned OCF_ALARM_MS = 227;
  localparam int unsigned OCF_HOLD_S = 4;
  localparam int unsigned OCF_ALARM_CYC = OCF_ALARM_MS * 1000 * OCF_CLK_MHZ;
  localparam longint unsigned OCF_HOLD_CYC = 64'(OCF_HOLD_S) * 1000000 * OCF_CLK_MHZ;
  localparam int unsigned OCF_CNT_W = 32;

  localparam logic [3:0] OCF_ADDR_CTRL = 4'h0;
  localparam logic [3:0] OCF_ADDR_STAT = 4'h4;
  localparam logic [3:0] OCF_ADDR_INT_STAT = 4'h8;
  localparam logic [3:0] OCF_ADDR_INT_MASK = 4'hc;

  // Control bits
  localparam int unsigned OCF_CTRL_TMR_RST = 0;
  localparam int unsigned OCF_CTRL_EXT = 1;
  localparam int unsigned OCF_CTRL_INIT = 2;
  // Event bits
  localparam int unsigned OCF_EV_ALARM = 0;
  localparam int unsigned OCF_EV_HOLD_DONE = 1;
  localparam int unsigned OCF_EV_ACK = 2;
  localparam int unsigned OCF_EV_W = 3;

  localparam logic [1:0] OCF_RESP_OKAY = 2'h0;
  localparam logic [1:0] OCF_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [OCF_CHAR_W-1:0] data;
    logic [2:0] connect;
    logic load_ack;
    logic select;
  } ocf_master_type;

  typedef struct packed {
    logic [OCF_CHAR_W-1:0] data;
    logic [OCF_UNITS-1:0] load_ack;
    logic daily_init;
  } ocf_unit_out_type;
endpackage

// ==== rtl/ocf_timer.sv ====
// Purpose: Restartable down-counter that flags expiry
// Assumes: restart has priority over counting
// Notes: Holds at zero once expired until restarted
`timescale 1ns/1ps
module ocf_timer
  import ocf_pkg::*;
#(
  parameter logic [OCF_CNT_W-1:0] COUNT = 32'h0000_0001
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic enable,
  input wire logic restart,
  // Status
  output logic expired
);
  logic [OCF_CNT_W-1:0] cnt_q;
  logic [OCF_CNT_W-1:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (restart)
    begin
      cnt_d = COUNT;
    end
    else if (enable && cnt_q != '0)
    begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= COUNT;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  assign expired = enable && (cnt_q == '0);
endmodule

// ==== rtl/ocf_fanout.sv ====
// Purpose: Output slave multiplexer between master multiplexer and eight serial output units
// Assumes: all pin inputs synchronous to aclk; registers over AXI4-Lite
// Notes: Alarm timer and start-up hold-off reach software as sticky interrupt events
// Notes on behaviour
// - Three connect bits form unit number 0 to 7 selecting one unit.
// - Load acknowledge reaches only the addressed unit, only while module selected.
// - Data-wanted requests of eight units merge into one request line.
// - Each request gated by connect decode before merging.
// - Merged request forwarded only while module select is asserted.
// - Outgoing character presented to all eight unit ports at once.
// - Daily init signal goes to all eight units together.
// - Alarm output and lamp raised after 227 ms without timer reset.
// - Extended variant holds transmission 4 seconds for printer motors.
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module ocf_fanout
  import ocf_pkg::*;
#(
  parameter logic [OCF_CNT_W-1:0] ALARM_CYCLES = OCF_CNT_W'(OCF_ALARM_CYC),
  parameter logic [OCF_CNT_W-1:0] HOLD_CYCLES = OCF_CNT_W'(OCF_HOLD_CYC)
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Master multiplexer side
  input wire ocf_master_type master_in,
  input wire logic timer_reset_pulse,
  input wire logic daily_init_in,
  output logic char_request,
  // Serial output unit side
  input wire logic [OCF_UNITS-1:0] unit_request,
  output ocf_unit_out_type unit_out,
  // Front panel and console
  input wire logic manual_reset,
  output logic alarm,
  output logic alarm_lamp,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic ext_q, ext_d;
  logic [OCF_EV_W-1:0] int_stat_q, int_stat_d;
  logic [OCF_EV_W-1:0] int_mask_q, int_mask_d;
  logic aw_got_q, aw_got_d;
  logic w_got_q, w_got_d;
  logic [3:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic sw_tmr_rst, sw_init;

  // ----------------------------------------------------------------
  // Routing and fan-in
  // ----------------------------------------------------------------
  logic [OCF_UNITS-1:0] unit_sel;
  logic hold_active;
  logic hold_expired;
  logic alarm_expired;
  logic hold_run_q, hold_run_d;
  logic alarm_q, alarm_d;
  ocf_unit_out_type unit_out_q, unit_out_d;
  logic init_any;
  logic timer_restart;

  assign unit_sel = OCF_UNITS'(1) << master_in.connect;
  assign init_any = daily_init_in | sw_init;
  assign hold_active = ext_q && hold_run_q && !hold_expired;

  always_comb
  begin
    unit_out_d = unit_out_q;
    unit_out_d.data = master_in.data;
    unit_out_d.daily_init = init_any;
    unit_out_d.load_ack = (master_in.select && master_in.load_ack) ? unit_sel : '0;
  end

  // Unit request presumed to rise again after its character is sent
  always_comb
  begin
    char_request = master_in.select && !hold_active && |(unit_request & unit_sel);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      unit_out_q <= '0;
    end
    else
    begin
      unit_out_q <= unit_out_d;
    end
  end
  assign unit_out = unit_out_q;

  // ----------------------------------------------------------------
  // Alarm timer and start-up hold-off
  // ----------------------------------------------------------------
  assign timer_restart = timer_reset_pulse | manual_reset | sw_tmr_rst;

  ocf_timer #(
    .COUNT(ALARM_CYCLES)
  ) u_alarm_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(1'b1),
    .restart(timer_restart),
    .expired(alarm_expired)
  );

  ocf_timer #(
    .COUNT(HOLD_CYCLES)
  ) u_hold_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(hold_run_q),
    .restart(init_any),
    .expired(hold_expired)
  );

  always_comb
  begin
    alarm_d = alarm_q;
    hold_run_d = hold_run_q;
    if (timer_restart)
    begin
      alarm_d = 1'b0;
    end
    else if (alarm_expired)
    begin
      alarm_d = 1'b1;
    end
    if (init_any && ext_q)
    begin
      hold_run_d = 1'b1;
    end
    else if (hold_expired)
    begin
      hold_run_d = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      alarm_q <= 1'b0;
      hold_run_q <= 1'b0;
    end
    else
    begin
      alarm_q <= alarm_d;
      hold_run_q <= hold_run_d;
    end
  end
  assign alarm = alarm_q;
  assign alarm_lamp = alarm_q;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic wr_fire;
  logic rd_fire;
  logic [OCF_EV_W-1:0] events;

  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign sw_tmr_rst = wr_fire && awaddr_q == OCF_ADDR_CTRL && wstrb_q[0] && wdata_q[OCF_CTRL_TMR_RST];
  assign sw_init = wr_fire && awaddr_q == OCF_ADDR_CTRL && wstrb_q[0] && wdata_q[OCF_CTRL_INIT];

  always_comb
  begin
    events = '0;
    events[OCF_EV_ALARM] = alarm_expired && !alarm_q && !timer_restart;
    events[OCF_EV_HOLD_DONE] = hold_run_q && hold_expired;
    events[OCF_EV_ACK] = master_in.select && master_in.load_ack;
  end

  always_comb
  begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    ext_d = ext_q;
    int_mask_d = int_mask_q;
    int_stat_d = int_stat_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = OCF_RESP_OKAY;
      unique case (awaddr_q)
        OCF_ADDR_CTRL:
        begin
          if (wstrb_q[0])
          begin
            ext_d = wdata_q[OCF_CTRL_EXT];
          end
        end
        OCF_ADDR_STAT:
        begin
        end
        OCF_ADDR_INT_STAT:
        begin
          if (wstrb_q[0])
          begin
            int_stat_d = int_stat_q & ~wdata_q[OCF_EV_W-1:0];
          end
        end
        OCF_ADDR_INT_MASK:
        begin
          if (wstrb_q[0])
          begin
            int_mask_d = wdata_q[OCF_EV_W-1:0];
          end
        end
        default:
        begin
          bresp_d = OCF_RESP_SLVERR;
        end
      endcase
    end
    // Set wins over a same-cycle clear
    int_stat_d = int_stat_d | events;
    if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
    if (rd_fire)
    begin
      rvalid_d = 1'b1;
      rresp_d = OCF_RESP_OKAY;
      rdata_d = '0;
      unique case (s_axi_araddr)
        OCF_ADDR_CTRL:
        begin
          rdata_d[OCF_CTRL_EXT] = ext_q;
        end
        OCF_ADDR_STAT:
        begin
          rdata_d = {18'h0_0000, hold_active, alarm_q, unit_request, master_in.connect, master_in.select};
        end
        OCF_ADDR_INT_STAT:
        begin
          rdata_d[OCF_EV_W-1:0] = int_stat_q;
        end
        OCF_ADDR_INT_MASK:
        begin
          rdata_d[OCF_EV_W-1:0] = int_mask_q;
        end
        default:
        begin
          rresp_d = OCF_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= OCF_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= OCF_RESP_OKAY;
      ext_q <= 1'b0;
      int_mask_q <= '0;
      int_stat_q <= '0;
    end
    else
    begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      ext_q <= ext_d;
      int_mask_q <= int_mask_d;
      int_stat_q <= int_stat_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign irq = |(int_stat_q & int_mask_q);
endmodule

// ==== verification/ocf_fanout_properties.sv ====
// Purpose: Port-level checks of the output channel fanout
// Assumes: one clock, synchronous active-low reset
// Notes: Quiet time counts pin restarts only, so software restarts only make the early-alarm check more lenient
`timescale 1ns/1ps
module ocf_fanout_properties
  import ocf_pkg::*;
#(
  parameter logic [OCF_CNT_W-1:0] ALARM_CYCLES = 32'h32,
  parameter logic [OCF_CNT_W-1:0] HOLD_CYCLES = 32'h64
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins
  input wire ocf_master_type master_in,
  input wire logic timer_reset_pulse,
  input wire logic daily_init_in,
  input wire logic char_request,
  input wire logic [OCF_UNITS-1:0] unit_request,
  input wire ocf_unit_out_type unit_out,
  input wire logic manual_reset,
  input wire logic alarm,
  input wire logic alarm_lamp,
  // Bus answers
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] quiet_q;
  logic [31:0] quiet_d;
  always_comb quiet_d = (timer_reset_pulse || manual_reset) ? 32'h0 : quiet_q + 32'h1;
  always_ff @(posedge aclk) quiet_q <= aresetn ? quiet_d : 32'h0;
  chk_ack_route: assert property (1 |=> unit_out.load_ack == ($past(master_in.select && master_in.load_ack) ?
    8'h1 << $past(master_in.connect) : 8'h0)) else $error("load ack misrouted");
  chk_data_bcast: assert property (1 |=> unit_out.data == $past(master_in.data))
    else $error("character not broadcast");
  chk_init_fan: assert property (daily_init_in |=> unit_out.daily_init)
    else $error("daily init not passed on");
  chk_req_gate: assert property (char_request |-> master_in.select && unit_request[master_in.connect])
    else $error("request not gated");
  chk_alarm_late: assert property (alarm |-> quiet_q + 32'h3 >= ALARM_CYCLES)
    else $error("alarm too early");
  chk_alarm_clear: assert property ((timer_reset_pulse || manual_reset) |=> !alarm)
    else $error("restart left alarm");
  chk_lamp_same: assert property (alarm_lamp == alarm)
    else $error("lamp not lit");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  cover property (unit_out.load_ack != 8'h0);
  cover property ($rose(alarm));
  cover property (daily_init_in ##1 !char_request);
endmodule

// ==== verification/ocf_unit_model.sv ====
// Purpose: Eight serial output units behind the fanout
// Assumes: one character load per routed acknowledge
// Notes: Unit i stays busy 2+2i cycles, so low units answer fast and high ones slowly
`timescale 1ns/1ps
module ocf_unit_model
  import ocf_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fanout side
  input wire ocf_unit_out_type unit_out,
  output logic [OCF_UNITS-1:0] unit_request,
  // Observation
  output logic [OCF_UNITS*OCF_CHAR_W-1:0] loaded
);
  logic [4:0] busy_q [OCF_UNITS];
  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < OCF_UNITS; i++)
    begin
      if (!aresetn)
      begin
        busy_q[i] <= 5'h0;
        loaded[i*8 +: 8] <= 8'h0;
      end
      else if (unit_out.load_ack[i])
      begin
        busy_q[i] <= 5'(2 + 2 * i);
        loaded[i*8 +: 8] <= unit_out.data;
      end
      else if (busy_q[i] != 5'h0)
        busy_q[i] <= busy_q[i] - 5'h1;
    end
  end
  always_comb
    for (int i = 0; i < OCF_UNITS; i++)
      unit_request[i] = (busy_q[i] == 5'h0);
endmodule

// ==== verification/ocf_fanout_tb.sv ====
// Purpose: Self-checking bench for the output channel fanout
// Assumes: short alarm and hold-off counts of 50 and 100 cycles
// Notes: Bench plays the master multiplexer and the register host
`timescale 1ns/1ps
module ocf_fanout_tb
  import ocf_pkg::*;
;
  localparam logic [31:0] ACYC = 32'h32;
  localparam logic [31:0] HCYC = 32'h64;
  logic aclk, aresetn, timer_reset_pulse, daily_init_in, char_request, manual_reset, alarm, alarm_lamp, irq;
  ocf_master_type master_in;
  ocf_unit_out_type unit_out;
  logic [7:0] unit_request;
  logic [63:0] loaded;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int fail_count = 0;
  int checks = 0;
  logic [15:0] r;
  logic [31:0] d;
  logic [1:0] rs;
  ocf_fanout #(.ALARM_CYCLES(ACYC), .HOLD_CYCLES(HCYC)) dut (.*);
  ocf_unit_model pm (.aclk, .aresetn, .unit_out, .unit_request, .loaded);
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [16:0] exp_out(ocf_master_type v);
    return {v.data, (v.select && v.load_ack) ? 8'h1 << v.connect : 8'h0, 1'b0};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] p);
    logic b;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Each channel drops its valid only after the edge that takes it
    while (!b)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      b = s_axi_bvalid;
      p = s_axi_bresp;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] p);
    logic b;
    b = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!b)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      b = s_axi_rvalid;
      v = s_axi_rdata;
      p = s_axi_rresp;
    end
    s_axi_rready <= 1'b0;
  endtask
  // 0 timer reset, 1 panel reset, 2 daily init
  task automatic pulse(input int unsigned which);
    @(posedge aclk);
    if (which == 0)
      timer_reset_pulse <= 1'b1;
    else if (which == 1)
      manual_reset <= 1'b1;
    else
      daily_init_in <= 1'b1;
    @(posedge aclk);
    {timer_reset_pulse, manual_reset, daily_init_in} <= 3'h0;
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial
  begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    conclude();
  end
  initial
  begin
    {aresetn, timer_reset_pulse, daily_init_in, manual_reset} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = 42'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    s_axi_wstrb = 4'hf;
    // Unit 5 selected, no acknowledge, so every unit still requests at the first read
    master_in = ocf_master_type'(13'h015);
    r = 16'h0002;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axr(OCF_ADDR_STAT, d, rs);
    check(d, 32'h0000_0ffb);
    axr(OCF_ADDR_INT_MASK, d, rs);
    check(d, 32'h0);
    axr(4'h2, d, rs);
    check(rs, OCF_RESP_SLVERR);
    $display("test registers done");
    for (int k = 0; k < 64; k++)
    begin
      @(posedge aclk);
      r = lfsr(r);
      // Acknowledge only a requesting unit, as a real master would
      master_in <= {r[15:8], r[2:0], r[3] & r[4] & unit_request[r[2:0]], r[4]};
      @(negedge aclk);
      check(char_request, master_in.select & unit_request[master_in.connect]);
      @(negedge aclk);
      check(unit_out, exp_out(master_in));
    end
    @(posedge aclk);
    master_in <= ocf_master_type'(13'h0);
    repeat (20) @(posedge aclk);
    // One hand-placed load to an idle unit
    master_in <= '{data: 8'h5a, connect: 3'h3, load_ack: unit_request[3], select: 1'b1};
    @(posedge aclk);
    master_in <= ocf_master_type'(13'h0);
    repeat (2) @(negedge aclk);
    check(loaded[31:24], 8'h5a);
    check(unit_request[3], 1'b0);
    $display("test routing done");
    pulse(0);
    axw(OCF_ADDR_INT_STAT, 32'h7, rs);
    axw(OCF_ADDR_INT_MASK, 32'h7, rs);
    check(rs, OCF_RESP_OKAY);
    repeat (25) @(posedge aclk);
    check(alarm, 1'b0);
    repeat (25) @(posedge aclk);
    check({alarm, alarm_lamp, irq}, 3'h7);
    axr(OCF_ADDR_INT_STAT, d, rs);
    check(d, 32'h1);
    axw(OCF_ADDR_INT_MASK, 32'h0, rs);
    check(irq, 1'b0);
    axw(OCF_ADDR_INT_STAT, 32'h7, rs);
    axw(OCF_ADDR_INT_MASK, 32'h7, rs);
    check(irq, 1'b0);
    axw(4'h6, 32'h7, rs);
    check(rs, OCF_RESP_SLVERR);
    pulse(1);
    @(negedge aclk);
    check(alarm, 1'b0);
    $display("test alarm done");
    axw(OCF_ADDR_CTRL, 32'h2, rs);
    axr(OCF_ADDR_CTRL, d, rs);
    check(d, 32'h2);
    master_in <= ocf_master_type'(13'h001);
    pulse(2);
    @(negedge aclk);
    check(unit_out.daily_init, 1'b1);
    repeat (HCYC - 2) @(posedge aclk);
    check(char_request, 1'b0);
    repeat (4) @(posedge aclk);
    check(char_request, 1'b1);
    axr(OCF_ADDR_INT_STAT, d, rs);
    check(d[1], 1'b1);
    // Software timer restart and software init in one write
    axw(OCF_ADDR_CTRL, 32'h7, rs);
    check(alarm, 1'b0);
    axr(OCF_ADDR_STAT, d, rs);
    check(d[13:12], 2'h2);
    $display("test hold-off done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(OCF_ADDR_CTRL, d, rs);
    check(d, 32'h0);
    axr(OCF_ADDR_INT_STAT, d, rs);
    check(d, 32'h0);
    $display("test reset done");
    conclude();
  end
endmodule
bind ocf_fanout ocf_fanout_properties #(.ALARM_CYCLES(ALARM_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) chk (.*);
